/* epp_port_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the parallel port.
 * Assumes a 50 MHz device clock and a 3-bit host register address.
 */
`ifndef EPP_PORT_CONSTS_SVH
`define EPP_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets on the host address lines
// ----------------------------------------------------------------
`define OFS_PORT_DATA      3'h0
`define OFS_STATUS         3'h1
`define OFS_CONTROL        3'h2
`define OFS_EPP_ADDRESS    3'h3
`define OFS_EPP_DATA_0     3'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_STROBE         0
`define CTL_AUTO_FEED      1
`define CTL_INIT           2
`define CTL_SELECT         3
`define CTL_IRQ_EN         4
`define CTL_DIR            5
`define CTL_RESET          8'h04

// ----------------------------------------------------------------
// Status register fields and peripheral input pin indices
// ----------------------------------------------------------------
`define STS_TIMEOUT        0
`define PIN_WAIT           0
`define PIN_ACK            1
`define PIN_PAPER_END      2
`define PIN_SELECTED       3
`define PIN_ERROR          4
`define PIN_RESET          5'h02   // Pin stages after reset, acknowledge idle high

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      20
`define WAIT_TIMEOUT_NS    10000
`define WAIT_TIMEOUT_CYC   (`WAIT_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

/* epp_port_pkg.sv */
/*
 * Types of the parallel port controller: cycle states and the state record.
 * Assumes nothing of its surroundings.
 */
package epp_port_pkg;

    // EPP cycle sequencer, Gray coded along idle-hold-strobe-finish
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_HOLD   = 2'h1,
        ST_STROBE = 2'h3,
        ST_FINISH = 2'h2
    } cyc_state_t;

    // Whole state of the controller
    typedef struct packed {
        cyc_state_t  st;           // Cycle sequencer
        logic        rd_s1;        // Read strobe, first stage
        logic        rd_s2;        // Read strobe, second stage
        logic        rd_p;         // Read strobe, previous
        logic        wr_s1;        // Write strobe, first stage
        logic        wr_s2;        // Write strobe, second stage
        logic        wr_p;         // Write strobe, previous
        logic [2:0]  a_s1;         // Host address, first stage
        logic [2:0]  a_s2;         // Host address, second stage
        logic [7:0]  d_s1;         // Host data, first stage
        logic [7:0]  d_s2;         // Host data, second stage
        logic [7:0]  pd_s1;        // Port data lines, first stage
        logic [7:0]  pd_s2;        // Port data lines, second stage
        logic [4:0]  pin_s1;       // Peripheral status pins, first stage
        logic [4:0]  pin_s2;       // Peripheral status pins, second stage
        logic        ack_p;        // Acknowledge, previous
        logic [7:0]  data_latch;   // Printer data latch
        logic [7:0]  ctrl;         // Control latch
        logic [7:0]  epp_out;      // Byte driven during EPP write
        logic [7:0]  rd_data;      // Byte sampled at the end of any completed EPP cycle
        logic [7:0]  host_q;       // Read data toward host
        logic        wait_timeout_flag;        // Wait time-out flag
        logic        is_read;      // Current cycle reads
        logic        is_addr;      // Current cycle is an address cycle
        logic        wr_hold;      // Host write strobe still active
        logic        wait_lo;      // Wait seen low in this cycle
        logic        irq;          // Interrupt pulse
        logic [9:0]  tcnt;         // Time-out counter
    } ctl_regs_t;

endpackage

/* epp_parallel_port_controller.sv */
/*
 * Parallel port controller with standard, bidirectional and EPP modes.
 * Assumes an asynchronous ISA-style host strobe bus and connector pins, all
 * synchronised here; mode inputs come from configuration logic on clk_i.
 */
`timescale 1ns/1ns
`include "epp_port_consts.svh"

module epp_parallel_port_controller
    import epp_port_pkg::*;
(
    input  wire logic        clk_i,                  // 50 MHz clock
    input  wire logic        rst_n_i,                // Async reset, low
    input  wire logic        epp_mode_i,             // EPP mode selected
    input  wire logic        spp_mode_i,             // Standard mode, direction locked out
    input  wire logic        epp_v17_i,              // Older EPP protocol
    input  wire logic [2:0]  host_addr_i,            // Register address
    input  wire logic        host_read_strobe_n_i,   // I/O read strobe, low
    input  wire logic        host_write_strobe_n_i,  // I/O write strobe, low
    input  wire logic [7:0]  host_data_bus_i,        // Data from host
    output logic      [7:0]  host_data_bus_o,        // Data toward host
    output logic             host_data_bus_oe_o,     // Host bus drive
    output logic             host_ready_o,           // Low stretches host access
    output logic             irq_o,                  // Acknowledge interrupt pulse
    input  wire logic [7:0]  port_data_lines_i,      // Connector data, in
    output logic      [7:0]  port_data_lines_o,      // Connector data, out
    output logic             port_data_lines_oe_o,   // Connector data drive
    output logic             write_direction_n_o,    // Strobe, or EPP write direction
    output logic             data_phase_strobe_n_o,  // Auto feed, or EPP data strobe
    output logic             addr_phase_strobe_n_o,  // Select, or EPP address strobe
    output logic             periph_init_n_o,        // Peripheral initialise, low
    input  wire logic        periph_wait_n_i,        // Busy, or EPP wait
    input  wire logic        ack_n_i,                // Acknowledge / interrupt
    input  wire logic        paper_end_i,            // Paper end
    input  wire logic        printer_selected_i,     // Printer selected
    input  wire logic        error_n_i               // Error, low
);
    import epp_port_pkg::*;

    // ----------------------------------------------------------------
    // State and decode
    // ----------------------------------------------------------------
    // Last count of the wait time-out window
    localparam logic [9:0] TIMEOUT_LAST = 10'(`WAIT_TIMEOUT_CYC - 1);

    ctl_regs_t r;        // Registered state
    ctl_regs_t nxt_r;    // Next state
    logic      busy;     // EPP cycle in progress
    logic      dir_in;   // Effective input direction

    // True when the address names an EPP port
    function automatic logic is_epp_port(input logic [2:0] a);
        is_epp_port = (a >= `OFS_EPP_ADDRESS);
    endfunction

    // Cycle in progress whenever the sequencer leaves idle
    // Standard mode keeps the port lines driven out
    assign busy   = (r.st != ST_IDLE);
    assign dir_in = r.ctrl[`CTL_DIR] & ~spp_mode_i;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        // Edge flags, decode and sampled wait level
        logic rd_lead;
        logic rd_trail;
        logic wr_lead;
        logic wr_trail;
        logic epp_hit;
        logic wait_hi;
        rd_lead  = 1'b0;
        rd_trail = 1'b0;
        wr_lead  = 1'b0;
        wr_trail = 1'b0;
        epp_hit  = 1'b0;
        wait_hi  = 1'b0;
        // Every field holds unless a branch below changes it
        nxt_r    = r;
        // Two-stage synchronisers for every host and connector input
        nxt_r.rd_s1  = host_read_strobe_n_i;
        nxt_r.rd_s2  = r.rd_s1;
        nxt_r.wr_s1  = host_write_strobe_n_i;
        nxt_r.wr_s2  = r.wr_s1;
        nxt_r.a_s1   = host_addr_i;
        nxt_r.a_s2   = r.a_s1;
        nxt_r.d_s1   = host_data_bus_i;
        nxt_r.d_s2   = r.d_s1;
        nxt_r.pd_s1  = port_data_lines_i;
        nxt_r.pd_s2  = r.pd_s1;
        nxt_r.pin_s1 = {error_n_i, printer_selected_i, paper_end_i, ack_n_i, periph_wait_n_i};
        nxt_r.pin_s2 = r.pin_s1;
        // Previous stage values for the edge detectors
        nxt_r.rd_p   = r.rd_s2;
        nxt_r.wr_p   = r.wr_s2;
        nxt_r.ack_p  = r.pin_s2[`PIN_ACK];
        // Strobe edges, active low strobes
        rd_lead  = ~r.rd_s2 & r.rd_p;
        rd_trail = r.rd_s2 & ~r.rd_p;
        wr_lead  = ~r.wr_s2 & r.wr_p;
        wr_trail = r.wr_s2 & ~r.wr_p;
        epp_hit  = epp_mode_i & is_epp_port(r.a_s2);
        wait_hi  = r.pin_s2[`PIN_WAIT];

        // Interrupt on acknowledge rising edge
        nxt_r.irq = r.ctrl[`CTL_IRQ_EN] & r.pin_s2[`PIN_ACK] & ~r.ack_p;

        // Register writes at trailing edge of the write strobe
        if (wr_trail && !busy) begin
            case (r.a_s2)
                `OFS_PORT_DATA: begin
                    // Printer data latch, driven while idle
                    nxt_r.data_latch = r.d_s2;
                end
                `OFS_STATUS: begin
                    // Only bit 0 acts; other bits are dropped
                    if (r.d_s2[`STS_TIMEOUT]) begin
                        nxt_r.wait_timeout_flag = 1'b0;
                    end
                end
                `OFS_CONTROL: begin
                    // Top bits accepted, but always read back as one
                    nxt_r.ctrl = r.d_s2;
                    if (spp_mode_i) begin
                        nxt_r.ctrl[`CTL_DIR] = 1'b0;
                    end
                end
                default: begin
                    // EPP ports start cycles on leading edge instead
                end
            endcase
        end

        // Write byte follows host bus until the strobe trails, then holds
        if (busy && r.wr_hold) begin
            nxt_r.epp_out = r.d_s2;
            // Strobe released: freeze the byte for the rest of the cycle
            if (wr_trail) begin
                nxt_r.wr_hold = 1'b0;
            end
        end

        // EPP cycle sequencer
        case (r.st)
            ST_IDLE: begin
                // Leading strobe on a mapped EPP port starts a cycle
                if ((rd_lead || wr_lead) && epp_hit) begin
                    nxt_r.is_read = rd_lead;
                    nxt_r.is_addr = (r.a_s2 == `OFS_EPP_ADDRESS);
                    nxt_r.wr_hold = wr_lead;
                    nxt_r.epp_out = r.d_s2;
                    nxt_r.tcnt    = 10'h000;
                    nxt_r.wait_lo = ~wait_hi;
                    // Newer version holds off while wait is high
                    if (epp_v17_i || !wait_hi) begin
                        nxt_r.st = ST_STROBE;
                    end else begin
                        nxt_r.st = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // Newer version: held off until wait goes low
                nxt_r.tcnt = r.tcnt + 10'h001;
                if (r.tcnt == TIMEOUT_LAST) begin
                    nxt_r.st = ST_FINISH;
                    // Wait went low: drive the strobe
                end else if (!wait_hi) begin
                    nxt_r.wait_lo = 1'b1;
                    nxt_r.st      = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // Strobe out; still counts toward the time-out
                nxt_r.tcnt = r.tcnt + 10'h001;
                if (!wait_hi) begin
                    nxt_r.wait_lo = 1'b1;
                end
                // Wait rose after being low: sample the port lines
                if (r.wait_lo && wait_hi) begin
                    nxt_r.rd_data = r.pd_s2;
                    nxt_r.st      = ST_FINISH;
                    // No answer in time: abort
                end else if (r.tcnt == TIMEOUT_LAST) begin
                    nxt_r.st = ST_FINISH;
                end
            end
            ST_FINISH: begin
                // Wait for the host strobe to be released
                if (r.rd_s2 && r.wr_s2) begin
                    nxt_r.wr_hold = 1'b0;
                    nxt_r.st      = ST_IDLE;
                end
            end
            default: begin
                // Unused code falls back to idle
                nxt_r.st = ST_IDLE;
            end
        endcase

        // Time-out set wins over a clear in the same cycle
        if ((r.st == ST_HOLD || r.st == ST_STROBE) && r.tcnt == TIMEOUT_LAST
            && !(r.st == ST_STROBE && r.wait_lo && wait_hi)) begin
            nxt_r.wait_timeout_flag = 1'b1;
        end

        // Read data toward the host
        case (r.a_s2)
            `OFS_PORT_DATA: begin
                // Port lines when input, latch when output
                nxt_r.host_q = dir_in ? r.pd_s2 : r.data_latch;
            end
            `OFS_STATUS: begin
                // Busy inverted, pin levels, two ones, time-out
                nxt_r.host_q = {~r.pin_s2[`PIN_WAIT], r.pin_s2[`PIN_ACK], r.pin_s2[`PIN_PAPER_END],
                                r.pin_s2[`PIN_SELECTED], r.pin_s2[`PIN_ERROR], 2'h3, r.wait_timeout_flag};
            end
            `OFS_CONTROL: begin
                // Top bits read as one, direction as in use
                nxt_r.host_q = {2'h3, dir_in, r.ctrl[4:0]};
            end
            default: begin
                // EPP ports return the byte sampled by the last completed EPP cycle, read or write
                nxt_r.host_q = r.rd_data;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Strobes idle high; control latch at its reset value
            r            <= '0;
            r.st         <= ST_IDLE;
            r.rd_s1      <= 1'b1;
            r.rd_s2      <= 1'b1;
            r.rd_p       <= 1'b1;
            r.wr_s1      <= 1'b1;
            r.wr_s2      <= 1'b1;
            r.wr_p       <= 1'b1;
            // Acknowledge stages idle high, so no false edge follows reset
            r.pin_s1     <= `PIN_RESET;
            r.pin_s2     <= `PIN_RESET;
            r.ack_p      <= 1'b1;
            r.ctrl       <= `CTL_RESET;
        end else begin
            r <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // Host side outputs
    // ----------------------------------------------------------------
    assign host_data_bus_o    = r.host_q;
    // Drive only while reading a mapped register
    assign host_data_bus_oe_o = ~r.rd_s2 & (~is_epp_port(r.a_s2) | epp_mode_i);
    // Hold the host off until an EPP cycle completes or times out
    assign host_ready_o       = (r.st == ST_IDLE) | (r.st == ST_FINISH);
    // One-cycle pulse per acknowledge rise
    assign irq_o              = r.irq;

    // ----------------------------------------------------------------
    // Connector outputs
    // ----------------------------------------------------------------
    // Idle: follow the data latch, the control register and its direction bit
    assign port_data_lines_o     = busy ? r.epp_out : r.data_latch;
    assign port_data_lines_oe_o  = busy ? ~r.is_read : ~dir_in;
    assign write_direction_n_o   = busy ? r.is_read : ~r.ctrl[`CTL_STROBE];
    assign data_phase_strobe_n_o = busy ? ~((r.st == ST_STROBE) & ~r.is_addr)
                                        : ~r.ctrl[`CTL_AUTO_FEED];
    assign addr_phase_strobe_n_o = busy ? ~((r.st == ST_STROBE) & r.is_addr)
                                        : ~r.ctrl[`CTL_SELECT];
    // Init follows control bit 2 in every mode
    assign periph_init_n_o       = r.ctrl[`CTL_INIT];

endmodule // epp_parallel_port_controller

/* epp_port_monitor.sv */
/* Port-level assertions for the parallel port controller.
   Assumes one clock clk_i and the asynchronous active-low reset rst_n_i. */
`timescale 1ns/1ns
module epp_port_monitor (
    input wire logic clk_i,                  // Device clock
    input wire logic rst_n_i,                // Reset, low
    input wire logic epp_mode_i,             // EPP mode
    input wire logic spp_mode_i,             // Standard mode
    input wire logic epp_v17_i,              // Older version
    input wire logic periph_wait_n_i,        // Wait pin
    input wire logic ack_n_i,                // Acknowledge pin
    input wire logic host_ready_o,           // Access may end
    input wire logic irq_o,                  // Interrupt pulse
    input wire logic port_data_lines_oe_o,   // Connector drive
    input wire logic write_direction_n_o,    // Write direction
    input wire logic data_phase_strobe_n_o,  // Data strobe
    input wire logic addr_phase_strobe_n_o   // Address strobe
);
    // ------------------------------------------------------------
    // Cycles that the host access has been stretched
    // ------------------------------------------------------------
    logic [9:0] low_cnt_ff;  // Stretch length
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) low_cnt_ff <= 10'h000;
        else if (host_ready_o) low_cnt_ff <= 10'h000;
        else if (low_cnt_ff != 10'h3FF) low_cnt_ff <= low_cnt_ff + 10'h001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_ONE_STROBE: assert property (!host_ready_o |-> (data_phase_strobe_n_o || addr_phase_strobe_n_o))
        else $error("both strobes low in a cycle");
    AST_DIR_MATCH: assert property (!host_ready_o && !(data_phase_strobe_n_o && addr_phase_strobe_n_o)
        |-> port_data_lines_oe_o == !write_direction_n_o)
        else $error("drive and write direction disagree");
    AST_TMO_BOUND: assert property (low_cnt_ff <= 10'h1F6)
        else $error("cycle outlived the time-out");
    AST_COMPLETE: assert property ($rose(host_ready_o) && low_cnt_ff < 10'h190
        |-> $past(periph_wait_n_i, 2) && $past(periph_wait_n_i, 3))
        else $error("cycle ended without wait high");
    AST_V19_HOLD: assert property (($fell(data_phase_strobe_n_o) || $fell(addr_phase_strobe_n_o))
        && !host_ready_o && !epp_v17_i |-> !(periph_wait_n_i && $past(periph_wait_n_i)
        && $past(periph_wait_n_i, 2) && $past(periph_wait_n_i, 3)))
        else $error("cycle started with wait high");
    AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
        else $error("interrupt longer than one cycle");
    AST_IRQ_CAUSE: assert property (irq_o |-> $past(ack_n_i, 3) && !$past(ack_n_i, 4))
        else $error("interrupt without acknowledge rise");
    AST_SPP_DIR: assert property (spp_mode_i && $past(spp_mode_i) && $past(spp_mode_i, 2) && $past(spp_mode_i, 3)
        && !epp_mode_i |-> port_data_lines_oe_o)
        else $error("standard mode not driving");
    AST_EPP_OFF: assert property (!epp_mode_i && !$past(epp_mode_i) |-> host_ready_o)
        else $error("EPP cycle outside EPP mode");
    // Main scenarios reached
    cover property (!host_ready_o ##1 host_ready_o);
    cover property (irq_o);
    cover property (low_cnt_ff > 10'h1C2);
    cover property ($fell(addr_phase_strobe_n_o) && !host_ready_o);
endmodule // epp_port_monitor

bind epp_parallel_port_controller epp_port_monitor i_epp_port_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .epp_mode_i(epp_mode_i), .spp_mode_i(spp_mode_i),
    .epp_v17_i(epp_v17_i), .periph_wait_n_i(periph_wait_n_i), .ack_n_i(ack_n_i),
    .host_ready_o(host_ready_o), .irq_o(irq_o), .port_data_lines_oe_o(port_data_lines_oe_o),
    .write_direction_n_o(write_direction_n_o), .data_phase_strobe_n_o(data_phase_strobe_n_o),
    .addr_phase_strobe_n_o(addr_phase_strobe_n_o));

/* epp_periph_model.sv */
/* Behavioural EPP peripheral on the connector side.
   Assumes the bench resolves the data wire from both drivers. */
`timescale 1ns/1ns
module epp_periph_model (
    input  wire logic       clk_i,      // Device clock
    input  wire logic       rst_n_i,    // Reset, low
    input  wire logic       dstb_n_i,   // Data strobe
    input  wire logic       astb_n_i,   // Address strobe
    input  wire logic       wdir_n_i,   // Write direction
    input  wire logic [7:0] pd_i,       // Resolved data wire
    input  wire logic       busy_i,     // Hold wait high
    input  wire logic       stall_i,    // Never finish
    input  wire logic [7:0] rd_byte_i,  // Byte returned on reads
    output logic            wait_n_o,   // Wait toward device
    output logic      [7:0] pd_o,       // Data from peripheral
    output logic      [7:0] got_o,      // Last byte written
    output logic            got_addr_o  // Last write was address
);
    logic [3:0] cnt_ff;   // Delay before release
    logic       rel_ff;   // Wait released
    logic [7:0] last_ff;  // Last wire value
    wire act = !dstb_n_i || !astb_n_i;
    // Answer each strobe after four cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 4'h0;
            rel_ff <= 1'b0;
            last_ff <= 8'h00;
            got_o <= 8'h00;
            got_addr_o <= 1'b0;
        end else begin
            last_ff <= pd_i;
            if (!act || busy_i) begin  // Ready for next transfer
                cnt_ff <= 4'h0;
                rel_ff <= 1'b0;
            end else if (cnt_ff < 4'h3) cnt_ff <= cnt_ff + 4'h1;
            else if (!stall_i && !rel_ff) begin  // Transfer done
                rel_ff <= 1'b1;
                if (!wdir_n_i) got_o <= pd_i;
                if (!wdir_n_i) got_addr_o <= !astb_n_i;
            end
        end
    end
    assign wait_n_o = busy_i || rel_ff;
    assign pd_o = (act && wdir_n_i) ? rd_byte_i : ~last_ff;
endmodule // epp_periph_model

/* epp_parallel_port_controller_tb.sv */
/* Self-checking bench for the parallel port controller.
   Assumes the peripheral model and the bound port checker. */
`timescale 1ns/1ns
module epp_parallel_port_controller_tb;
    logic       clk_i, rst_n_i, epp_mode, spp_mode, v17, hrd_n, hwr_n, ack_n, busy, stall;
    logic [2:0] haddr;
    logic [7:0] hdin, rd_byte, hdo, pdo, m_pd, got, pd_wire, q;
    logic       hoe, rdy, irq, pdoe, wdir_n, dstb_n, astb_n, init_n, m_wait_n, got_addr, oe_seen;
    int         num_errors = 0, compares = 0, lowc, irq_cnt = 0, cyc = 0, t1;
    assign pd_wire = pdoe ? pdo : m_pd;
    epp_parallel_port_controller i_epp_parallel_port_controller (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .epp_mode_i(epp_mode), .spp_mode_i(spp_mode), .epp_v17_i(v17),
        .host_addr_i(haddr), .host_read_strobe_n_i(hrd_n), .host_write_strobe_n_i(hwr_n),
        .host_data_bus_i(hdin), .host_data_bus_o(hdo), .host_data_bus_oe_o(hoe), .host_ready_o(rdy),
        .irq_o(irq), .port_data_lines_i(pd_wire), .port_data_lines_o(pdo), .port_data_lines_oe_o(pdoe),
        .write_direction_n_o(wdir_n), .data_phase_strobe_n_o(dstb_n), .addr_phase_strobe_n_o(astb_n),
        .periph_init_n_o(init_n), .periph_wait_n_i(m_wait_n), .ack_n_i(ack_n), .paper_end_i(1'b0),
        .printer_selected_i(1'b1), .error_n_i(1'b1));
    epp_periph_model i_epp_periph_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .dstb_n_i(dstb_n), .astb_n_i(astb_n), .wdir_n_i(wdir_n),
        .pd_i(pd_wire), .busy_i(busy), .stall_i(stall), .rd_byte_i(rd_byte), .wait_n_o(m_wait_n),
        .pd_o(m_pd), .got_o(got), .got_addr_o(got_addr));
    // ------------------------------------------------------------
    // Clock, interrupt count and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        cyc++;
        if (irq === 1'b1) irq_cnt++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h got %h", nm, e, g);
        end
    endtask
    // One host strobe access, held until the port lets it end
    task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        lowc = 0;
        oe_seen = 1'b0;
        @(posedge clk_i);
        haddr <= a;
        hdin <= d;
        hwr_n <= !wr;
        hrd_n <= wr;
        do begin
            @(posedge clk_i);
            #1 n++;
            lowc += !rdy;
            oe_seen |= hoe;
        end while ((n < 8 || rdy !== 1'b1) && n < 800);
        repeat (2) @(posedge clk_i);
        #1 q = hdo;
        @(posedge clk_i);
        hwr_n <= 1'b1;
        hrd_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input string nm, input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        acc(1'b0, a, 8'h00);
        cmp(nm, e & m, q & m);
    endtask
    task automatic pins(input logic [7:0] e);
        cmp("pins", e, {3'h0, pdoe, wdir_n, dstb_n, astb_n, init_n});
    endtask
    task automatic ack_pulse();
        @(posedge clk_i) ack_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        ack_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n_i, epp_mode, spp_mode, v17, busy, stall, haddr, hdin, rd_byte} = '0;
        {hrd_n, hwr_n, ack_n} = 3'h7;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 pins(8'h1F);
        rd("ctrl_reset", 3'h2, 8'hC4, 8'hFF);
        cmp("oe_mapped", 8'h01, {7'h0, oe_seen});
        acc(1'b1, 3'h2, 8'h2A);
        rd("ctrl_dir_in", 3'h2, 8'hEA, 8'hFF);
        pins(8'h08);
        repeat (2510) @(posedge clk_i);
        @(posedge clk_i) spp_mode <= 1'b1;
        acc(1'b1, 3'h0, 8'hA5);
        rd("port_rd", 3'h0, 8'hA5, 8'hFF);
        acc(1'b1, 3'h2, 8'h25);
        rd("ctrl_spp", 3'h2, 8'hC5, 8'hFF);
        pins(8'h17);
        cmp("port_out", 8'hA5, pdo);
        acc(1'b1, 3'h2, 8'h14);
        ack_pulse();
        cmp("irq_on", 8'h01, 8'(irq_cnt));
        acc(1'b1, 3'h2, 8'h04);
        ack_pulse();
        cmp("irq_off", 8'h01, 8'(irq_cnt));
        acc(1'b0, 3'h4, 8'h00);
        cmp("unmapped_oe", 8'h00, {7'h0, oe_seen});
        acc(1'b1, 3'h3, 8'h3C);
        cmp("unmapped_cycle", 8'h00, 8'(lowc));
        @(posedge clk_i) epp_mode <= 1'b1;
        spp_mode <= 1'b0;
        acc(1'b1, 3'h3, 8'h3C);
        cmp("addr_wr", 8'h3C, got);
        cmp("addr_kind", 8'h01, {7'h0, got_addr});
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 3'(4 + i), 8'(8'h50 + i));
            cmp("data_wr", 8'(8'h50 + i), got);
            cmp("data_kind", 8'h00, {7'h0, got_addr});
        end
        @(posedge clk_i) rd_byte <= 8'h96;
        rd("data_rd", 3'h4, 8'h96, 8'hFF);
        @(posedge clk_i) rd_byte <= 8'h69;
        rd("addr_rd", 3'h3, 8'h69, 8'hFF);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_i) v17 <= v[0];
            busy <= 1'b1;
            fork
                acc(1'b1, 3'h5, 8'(8'h70 + v));
                begin
                    repeat (20) @(posedge clk_i);
                    #1 cmp("start_gate", {7'h0, !v[0]}, {7'h0, dstb_n});
                    @(posedge clk_i) busy <= 1'b0;
                end
            join
            cmp("gated_wr", 8'(8'h70 + v), got);
        end
        @(posedge clk_i) v17 <= 1'b0;
        stall <= 1'b1;
        acc(1'b1, 3'h4, 8'h11);
        t1 = lowc;
        cmp("tmo_len", 8'h32, 8'((t1 + 5) / 10));
        rd("tmo_set", 3'h1, 8'h01, 8'h01);
        acc(1'b1, 3'h1, 8'h00);
        rd("tmo_keep", 3'h1, 8'h01, 8'h01);
        acc(1'b1, 3'h1, 8'h01);
        rd("tmo_clr", 3'h1, 8'h00, 8'h01);
        acc(1'b1, 3'h6, 8'h22);
        cmp("tmo_restart", 8'h00, 8'(lowc - t1));
        wrap_up();
    end
endmodule // epp_parallel_port_controller_tb
